/* inc/mbac_defs.svh */
`ifndef MBAC_DEFS_SVH
`define MBAC_DEFS_SVH

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define MBAC_ADDR_W       8
`define MBAC_ROW_W        3
`define MBAC_COL_W        5
`define MBAC_ROW_LSB      5
`define MBAC_ILLEGAL_ROW  3'h0
`define MBAC_ILLEGAL_COL  5'h1F
`define MBAC_ACCESS_ROW   3'h0
`define MBAC_FACTORY_ADDR 8'h09

// ----------------------------------------------------------------
// driver cards and channels
// ----------------------------------------------------------------
`define MBAC_MAX_CARDS    8
`define MBAC_CONN_PER_CARD 31
`define MBAC_CARD_STEP    100
`define MBAC_CHAN_W       10

`endif

/* inc/mbac_pkg.sv */
package mbac_pkg;
  typedef enum logic [1:0] {
    MBAC_SRC_SWITCH,
    MBAC_SRC_SOFT
  } mbac_src_t;
endpackage

/* design/mbac_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mbac_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] d_reg;

  // a zero-width bus has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  // two stages; the first is read by the second only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      d_reg    <= '0;
    end else begin
      meta_reg <= d_in;
      d_reg    <= meta_reg;
    end
  end
  assign d_out = d_reg;
endmodule
`default_nettype wire

/* design/mbac_chanmap.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbac_defs.svh"
module mbac_chanmap (
  // connector selection
  input  wire logic [3:0]             card,
  input  wire logic [4:0]             conn,
  input  wire logic                   builtin_card,
  // result
  output logic      [`MBAC_CHAN_W-1:0] chan,
  output logic                         chan_ok
);
  localparam logic [`MBAC_CHAN_W-1:0] CARD_STEP = `MBAC_CHAN_W'(`MBAC_CARD_STEP);
  logic [`MBAC_CHAN_W-1:0] base;
  logic                    card_ok;
  logic                    conn_ok;

  // channel = card*100 + connector - 1
  assign base    = CARD_STEP * {6'h00, card};
  assign card_ok = builtin_card ? (card == 4'h1)
                                : (card >= 4'h1 && card <= 4'(`MBAC_MAX_CARDS));
  assign conn_ok = (conn >= 5'h01) && (conn <= 5'(`MBAC_CONN_PER_CARD));
  assign chan_ok = card_ok && conn_ok;
  assign chan    = chan_ok ? base + {5'h00, conn} - 10'h001 : 10'h000;
endmodule
`default_nettype wire

/* design/mbac_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbac_defs.svh"
module mbac_top
  import mbac_pkg::*;
#(
  parameter logic [`MBAC_ADDR_W-1:0] FACTORY_ADDR = `MBAC_FACTORY_ADDR
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  // switches and bus reset, asynchronous pins
  input  wire logic [`MBAC_COL_W-1:0]  col_sw,
  input  wire logic [`MBAC_ROW_W-1:0]  row_sw,
  input  wire logic                    bus_reset,
  // soft-set address from display
  input  wire logic                    soft_we,
  input  wire logic [`MBAC_COL_W-1:0]  soft_addr,
  // driver card lookup
  input  wire logic                    builtin_card,
  input  wire logic [3:0]              card_sel,
  input  wire logic [4:0]              conn_sel,
  // results
  output logic      [`MBAC_ADDR_W-1:0] bus_addr,
  output logic      [`MBAC_COL_W-1:0]  ieee_addr,
  output logic                         addr_illegal,
  output logic                         ieee_enable,
  output logic                         soft_active,
  output logic      [`MBAC_CHAN_W-1:0] chan_num,
  output logic                         chan_valid
);
  // refused at elaboration: the factory setting must be a usable address
  if (FACTORY_ADDR == {`MBAC_ILLEGAL_ROW, `MBAC_ILLEGAL_COL}) begin : g_bad_factory
    $error("factory address may not be the illegal address");
  end

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [`MBAC_ADDR_W:0] sw_sync;
  logic                  bus_reset_s;
  logic [`MBAC_ROW_W-1:0] row_s;
  logic [`MBAC_COL_W-1:0] col_s;

  mbac_sync #(.W(`MBAC_ADDR_W + 1)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d_in    ({bus_reset, row_sw, col_sw}),
    .d_out   (sw_sync)
  );
  assign bus_reset_s = sw_sync[`MBAC_ADDR_W];
  assign row_s       = sw_sync[`MBAC_ADDR_W-1:`MBAC_ROW_LSB];
  assign col_s       = sw_sync[`MBAC_COL_W-1:0];

  // ----------------------------------------------------------------
  // switch capture
  // ----------------------------------------------------------------
  // sampling waits for the synchroniser to settle after release
  logic [1:0]              settle_reg;
  logic                    capture;
  logic [`MBAC_ROW_W-1:0]  row_reg;
  logic [`MBAC_COL_W-1:0]  col_reg;

  assign capture = (settle_reg == 2'h2) || bus_reset_s;

  // settle counter runs once after release; bus reset captures directly
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // switches held between capture events; factory value until first sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      row_reg <= FACTORY_ADDR[`MBAC_ADDR_W-1:`MBAC_ROW_LSB];
      col_reg <= FACTORY_ADDR[`MBAC_COL_W-1:0];
    end else if (capture) begin
      row_reg <= row_s;
      col_reg <= col_s;
    end
  end

  // ----------------------------------------------------------------
  // soft-set override
  // ----------------------------------------------------------------
  mbac_src_t              src_reg;
  logic [`MBAC_COL_W-1:0] soft_reg;

  // bus reset beats a same-cycle write: the override must not survive it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      src_reg  <= MBAC_SRC_SWITCH;
      soft_reg <= 5'h00;
    end else if (bus_reset_s) begin
      src_reg  <= MBAC_SRC_SWITCH;
    end else if (soft_we) begin
      src_reg  <= MBAC_SRC_SOFT;
      soft_reg <= soft_addr;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [`MBAC_COL_W-1:0]  col_eff;
  logic [`MBAC_ADDR_W-1:0] addr_next;
  logic                    illegal_next;
  logic                    ieee_next;

  assign col_eff      = (src_reg == MBAC_SRC_SOFT) ? soft_reg : col_reg;
  assign addr_next    = {row_reg, col_eff};
  assign illegal_next = (row_reg == `MBAC_ILLEGAL_ROW) &&
                        (col_eff == `MBAC_ILLEGAL_COL);
  assign ieee_next    = (row_reg == `MBAC_ACCESS_ROW) && !illegal_next;

  // ----------------------------------------------------------------
  // channel lookup
  // ----------------------------------------------------------------
  logic [`MBAC_CHAN_W-1:0] chan_next;
  logic                    chan_ok_next;

  mbac_chanmap u_map (
    .card         (card_sel),
    .conn         (conn_sel),
    .builtin_card (builtin_card),
    .chan         (chan_next),
    .chan_ok      (chan_ok_next)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_addr     <= FACTORY_ADDR;
      ieee_addr    <= 5'h00;
      addr_illegal <= 1'b0;
      ieee_enable  <= 1'b0;
      soft_active  <= 1'b0;
      chan_num     <= 10'h000;
      chan_valid   <= 1'b0;
    end else begin
      bus_addr     <= addr_next;
      ieee_addr    <= col_eff;
      addr_illegal <= illegal_next;
      ieee_enable  <= ieee_next;
      soft_active  <= (src_reg == MBAC_SRC_SOFT);
      chan_num     <= chan_next;
      chan_valid   <= chan_ok_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_soft_write;
    !bus_reset_s && soft_we;
  endsequence

  property p_row_top;
    @(posedge sys_clk) disable iff (!resetn)
      1 |=> bus_addr[7:5] == $past(row_reg);
  endproperty
  a_row_top: assert property (p_row_top) else $error("row not in top bits");

  property p_col_low;
    @(posedge sys_clk) disable iff (!resetn)
      (src_reg == MBAC_SRC_SWITCH) |=> bus_addr[4:0] == $past(col_reg);
  endproperty
  a_col_low: assert property (p_col_low) else $error("column not in low bits");

  property p_illegal;
    @(posedge sys_clk) disable iff (!resetn)
      (addr_next == 8'h1F) |=> addr_illegal && !ieee_enable;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal address not flagged");

  property p_ieee_row;
    @(posedge sys_clk) disable iff (!resetn)
      ieee_enable |-> bus_addr[7:5] == 3'h0 && bus_addr[4:0] != 5'h1F;
  endproperty
  a_ieee_row: assert property (p_ieee_row) else $error("bus access off row zero");

  property p_soft_override;
    @(posedge sys_clk) disable iff (!resetn)
      s_soft_write |=> ##1 (ieee_addr == $past(soft_addr, 2) && soft_active);
  endproperty
  a_soft_override: assert property (p_soft_override) else $error("soft address ignored");

  property p_reset_drop;
    @(posedge sys_clk) disable iff (!resetn)
      bus_reset_s |=> ##1 !soft_active;
  endproperty
  a_reset_drop: assert property (p_reset_drop) else $error("soft address kept");

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
      !capture |=> $stable(row_reg) && $stable(col_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("switch sample moved");

  property p_chan;
    @(posedge sys_clk) disable iff (!resetn)
      chan_ok_next |=> chan_num == 10'(100 * $past(card_sel) + $past(conn_sel) - 1);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel number");

  property p_cards;
    @(posedge sys_clk) disable iff (!resetn)
      chan_valid |-> $past(card_sel) >= 4'h1 && $past(card_sel) <= 4'h8 &&
                     (!$past(builtin_card) || $past(card_sel) == 4'h1);
  endproperty
  a_cards: assert property (p_cards) else $error("card out of range");
endmodule
`default_nettype wire

/* verification/mbac_disp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// display side: hands soft-set addresses to the module
// ----------------------------------------------------------------
module mbac_disp_model (
  // clock
  input  wire logic       sys_clk,
  // soft-set address towards the module
  output logic            soft_we,
  output logic [4:0]      soft_addr
);
  // idle: no write, address lines parked on an ordinary column value, 5'h15
  initial begin
    soft_we   = 1'b0;
    soft_addr = 5'h15;
  end

  // one-cycle write pulse, launched just after an edge
  task automatic send(input logic [4:0] a);
    @(posedge sys_clk);
    #1;
    soft_we   = 1'b1;
    soft_addr = a;
    @(posedge sys_clk);
    #1;
    soft_we   = 1'b0;
    soft_addr = ~a;  // released lines flip, so a stale value is never trusted
  endtask
endmodule
`default_nettype wire

/* verification/mbac_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mbac_top_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       sys_clk, resetn, bus_reset, builtin_card, soft_we, soft_active;
  logic       addr_illegal, ieee_enable, chan_valid;
  logic [4:0] col_sw, soft_addr, conn_sel, ieee_addr;
  logic [2:0] row_sw;
  logic [3:0] card_sel;
  logic [7:0] bus_addr;
  logic [9:0] chan_num;
  int         fails, checked;

  typedef struct {
    logic [2:0] row; logic [4:0] col; logic [3:0] card; logic [4:0] conn; logic bi;
    logic [9:0] chan; logic ok; logic ill; logic en;
  } mbac_row_t;

  // each row a distinct element address
  mbac_row_t rows [9] = '{
    '{3'h0, 5'h09, 4'h1, 5'h01, 1'b0, 10'h064, 1'b1, 1'b0, 1'b1},
    '{3'h0, 5'h1F, 4'h8, 5'h1F, 1'b0, 10'h33E, 1'b1, 1'b1, 1'b0},
    '{3'h7, 5'h00, 4'h1, 5'h1F, 1'b0, 10'h082, 1'b1, 1'b0, 1'b0},
    '{3'h2, 5'h18, 4'h9, 5'h01, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0},
    '{3'h0, 5'h00, 4'h8, 5'h01, 1'b0, 10'h320, 1'b1, 1'b0, 1'b1},
    '{3'h1, 5'h1F, 4'h1, 5'h00, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0},
    '{3'h0, 5'h1E, 4'h2, 5'h01, 1'b1, 10'h000, 1'b0, 1'b0, 1'b1},
    '{3'h3, 5'h05, 4'h1, 5'h05, 1'b1, 10'h068, 1'b1, 1'b0, 1'b0},
    '{3'h0, 5'h05, 4'h0, 5'h01, 1'b0, 10'h000, 1'b0, 1'b0, 1'b1}
  };

  mbac_top i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .col_sw(col_sw), .row_sw(row_sw),
    .bus_reset(bus_reset), .soft_we(soft_we), .soft_addr(soft_addr),
    .builtin_card(builtin_card), .card_sel(card_sel), .conn_sel(conn_sel),
    .bus_addr(bus_addr), .ieee_addr(ieee_addr), .addr_illegal(addr_illegal),
    .ieee_enable(ieee_enable), .soft_active(soft_active), .chan_num(chan_num),
    .chan_valid(chan_valid)
  );

  mbac_disp_model i_disp (.sys_clk(sys_clk), .soft_we(soft_we), .soft_addr(soft_addr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // after the power-up sample, switches only land through a bus reset, held long enough for the sync
  task automatic bus_rst(input logic [2:0] r, input logic [4:0] c);
    row_sw    = r;
    col_sw    = c;
    bus_reset = 1'b1;
    cyc(4);
    bus_reset = 1'b0;
    cyc(6);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // bounded run: all tests need well under 1000 cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0; checked = 0;
    resetn = 1'b0; bus_reset = 1'b0; builtin_card = 1'b0;
    row_sw = 3'h5; col_sw = 5'h1A; card_sel = 4'h1; conn_sel = 5'h01;
    cyc(8);
    chk("bus_addr_rst", 10'(bus_addr), 10'h009);
    chk("soft_rst", 10'(soft_active), 10'h000);
    resetn = 1'b1;
    cyc(6);
    chk("bus_addr_pwr", 10'(bus_addr), 10'h0BA);
    // table of switch settings and connector lookups
    foreach (rows[i]) begin
      card_sel = rows[i].card; conn_sel = rows[i].conn; builtin_card = rows[i].bi;
      bus_rst(rows[i].row, rows[i].col);
      chk("bus_addr", 10'(bus_addr), 10'({rows[i].row, rows[i].col}));
      chk("ieee_addr", 10'(ieee_addr), 10'(rows[i].col));
      chk("illegal", 10'(addr_illegal), 10'(rows[i].ill));
      chk("ieee_en", 10'(ieee_enable), 10'(rows[i].en));
      chk("chan_num", chan_num, rows[i].chan);
      chk("chan_ok", 10'(chan_valid), 10'(rows[i].ok));
    end
    // switches moved without a reset event must not show
    row_sw = 3'h6; col_sw = 5'h02;
    cyc(6);
    chk("hold", 10'(bus_addr), 10'h005);
    // two soft writes one idle cycle apart, ascending column, last one wins
    bus_rst(3'h0, 5'h03);
    i_disp.send(5'h0C);
    i_disp.send(5'h11);
    cyc(3);
    chk("soft_addr", 10'(ieee_addr), 10'h011);
    chk("soft_on", 10'(soft_active), 10'h001);
    chk("soft_bus", 10'(bus_addr), 10'h011);
    // bus reset drops the override, and a write during it is refused
    bus_reset = 1'b1;
    cyc(4);
    i_disp.send(5'h07);
    cyc(3);
    chk("soft_refused", 10'(soft_active), 10'h000);
    bus_reset = 1'b0;
    cyc(6);
    chk("back_to_sw", 10'(ieee_addr), 10'h003);
    // power cycle drops the override too
    i_disp.send(5'h1E);
    cyc(3);
    chk("soft_on2", 10'(soft_active), 10'h001);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(6);
    chk("soft_pwr", 10'(soft_active), 10'h000);
    chk("addr_pwr", 10'(ieee_addr), 10'h003);
    stop_test;
  end
endmodule
`default_nettype wire
